// *** inc/sar_ctrl_pkg.sv ***
// shared constants and types for the converter control block
package sar_ctrl_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int RES_W = 16;
   localparam int CFG_W = 8;
   localparam int FRAME_W = RES_W + CFG_W;
   localparam int AXI_AW = 8;
   localparam int SEQ_DEPTH_DEF = 16;
   localparam int SEQ_AW = 4;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [AXI_AW-1:0] REG_RESULT = 8'h08;

   // control register fields
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int CTRL_TWOS_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NAP_BIT = 1;
   localparam int STAT_SLEEP_BIT = 2;
   localparam int STAT_RESET_BIT = 3;
   localparam int STAT_DEPTH_LSB = 4;
   localparam int STAT_INDEX_LSB = 12;

   // ------------------------------------------------------------
   // configuration word layout
   // ------------------------------------------------------------
   localparam int CFG_VALID_BIT = 7;
   localparam int CFG_MUX_LSB = 3;
   localparam int CFG_RNG_LSB = 1;
   localparam int CFG_GC_BIT = 0;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [1:0] RNG_FULL_DIFF = 2'h0;
   localparam logic [1:0] RNG_UNIPOLAR = 2'h1;
   localparam logic [1:0] RNG_BIPOLAR = 2'h2;

   // ------------------------------------------------------------
   // timing and answers
   // ------------------------------------------------------------
   localparam int SETTLE_CYCLES = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_NAP, ST_SLEEP, ST_CONV} conv_state_t;

endpackage : sar_ctrl_pkg

// *** inc/seq_mem_if.sv ***
// carrier between the control core and the sequencer memory
`timescale 1ns/100ps
interface seq_mem_if #(parameter int AW = 4, parameter int DW = 8);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : seq_mem_if

// *** core/seq_mem.sv ***
// sequencer word memory with registered read data
`timescale 1ns/100ps
module seq_mem #(
   parameter int DEPTH = 16,
   parameter int AW = 4,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   seq_mem_if.mem port
);

   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] words;
      logic [DW-1:0] rd;
   } mem_state_t;

   mem_state_t s_q;
   mem_state_t s_d;

   // read sees the old word on a same-cycle write, out of a register one cycle later
   always_comb begin
      s_d = s_q;
      if (port.wr_en) begin
         s_d.words[port.wr_addr] = port.wr_data;
      end
      s_d.rd = s_q.words[port.rd_addr];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign port.rd_data = s_q.rd;

endmodule : seq_mem

// *** core/sar_conv_ctrl.sv ***
// successive approximation converter control with serial readout link
//
// Functional notes
// - convert strobe rising edge wakes and starts conversion
// - busy high from start until conversion completes
// - bus enable low enables link, else hi-z
// - shift clock edges ignored while bus disabled
// - serial input sampled on rising shift edges
// - result then config shifted out, msb first
// - config word selects mux, range, gain compression
// - output format follows configured operating mode
// - reset pin halts conversion, output goes hi-z
// - sequencer holds one to sixteen words
// - range chosen independently of channel selection
// - automatic nap between conversions, strobe wakes
// - sixteen binary weighted trial steps, msb first
// - readout: result, used config; new word in
// - sleep mode below nap power
// - range fixes format, full differential selectable
// - straight binary is twos complement msb inverted
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module sar_conv_ctrl #(
   parameter int SEQ_DEPTH = sar_ctrl_pkg::SEQ_DEPTH_DEF,
   parameter int SETTLE = sar_ctrl_pkg::SETTLE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [sar_ctrl_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sar_ctrl_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic convert_strobe,
   input wire logic reset_in,
   input wire logic comp_in,
   output logic busy,
   output logic nap,
   output logic sleep_state,
   output logic [sar_ctrl_pkg::RES_W-1:0] dac_code,
   output logic [3:0] mux_config,
   output logic [1:0] input_range,
   output logic gain_compression,
   input wire logic shift_clk,
   input wire logic bus_enable_low,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_en
);

   localparam int RW = sar_ctrl_pkg::RES_W;
   localparam int CW = sar_ctrl_pkg::CFG_W;
   localparam int FW = sar_ctrl_pkg::FRAME_W;
   localparam int IW = $clog2(RW);
   localparam int AW = sar_ctrl_pkg::SEQ_AW;

   // ------------------------------------------------------------
   // state records
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] ben_s;
      logic [2:0] cnv_s;
      logic [1:0] rpin_s;
      logic [1:0] comp_s;
      logic [2:0] rdy_s;
      sar_ctrl_pkg::conv_state_t st;
      logic [IW-1:0] bit_idx;
      logic [7:0] wait_cnt;
      logic [RW-1:0] code;
      logic [RW-1:0] dac;
      logic [CW-1:0] cfg;
      logic [FW-1:0] hold;
      logic [AW:0] depth;
      logic [AW-1:0] seq_rd;
      logic seq_new;
      logic word_seen;
      logic sleep_req;
      logic fd_twos;
      logic aw_have;
      logic [sar_ctrl_pkg::AXI_AW-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } core_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic [CW-1:0] cfg_sh;
      logic rdy;
   } link_t;

   core_t c_q;
   core_t c_d;
   link_t l_q;
   link_t l_d;
   logic [1:0] rst_sync_q;
   logic rst_n_q;
   logic link_clr;
   logic dev_reset;
   logic cnv_rise;
   logic frame_end;
   logic word_new;
   logic keep;
   logic [RW-1:0] next_code;

   seq_mem_if #(.AW(AW), .DW(CW)) seq_port ();

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [RW-1:0] weight(input logic [IW-1:0] idx);
      logic [RW-1:0] w;
      w = '0;
      w[idx] = 1'b1;
      return w;
   endfunction : weight

   // raw sar code is offset binary; the msb flip gives twos complement
   function automatic logic [RW-1:0] format_code(input logic [RW-1:0] raw, input logic [CW-1:0] cfg,
                                                 input logic fd_twos);
      logic [1:0] rng;
      logic twos;
      rng = cfg[sar_ctrl_pkg::CFG_RNG_LSB +: 2];
      twos = (rng == sar_ctrl_pkg::RNG_BIPOLAR) || (rng == sar_ctrl_pkg::RNG_FULL_DIFF && fd_twos);
      return twos ? {~raw[RW-1], raw[RW-2:0]} : raw;
   endfunction : format_code

   function automatic logic [31:0] read_word(input logic [sar_ctrl_pkg::AXI_AW-1:0] addr, input core_t s,
                                             input logic in_reset);
      logic [31:0] r;
      r = '0;
      if (addr == sar_ctrl_pkg::REG_CTRL) begin
         r[sar_ctrl_pkg::CTRL_SLEEP_BIT] = s.sleep_req;
         r[sar_ctrl_pkg::CTRL_TWOS_BIT] = s.fd_twos;
      end else if (addr == sar_ctrl_pkg::REG_STATUS) begin
         r[sar_ctrl_pkg::STAT_BUSY_BIT] = (s.st == sar_ctrl_pkg::ST_CONV);
         r[sar_ctrl_pkg::STAT_NAP_BIT] = (s.st == sar_ctrl_pkg::ST_NAP);
         r[sar_ctrl_pkg::STAT_SLEEP_BIT] = (s.st == sar_ctrl_pkg::ST_SLEEP);
         r[sar_ctrl_pkg::STAT_RESET_BIT] = in_reset;
         r[sar_ctrl_pkg::STAT_DEPTH_LSB +: AW+1] = s.depth;
         r[sar_ctrl_pkg::STAT_INDEX_LSB +: AW] = s.seq_rd;
      end else if (addr == sar_ctrl_pkg::REG_RESULT) begin
         r[FW-1:0] = s.hold;
      end
      return r;
   endfunction : read_word

   function automatic logic mapped(input logic [sar_ctrl_pkg::AXI_AW-1:0] addr);
      return addr == sar_ctrl_pkg::REG_CTRL || addr == sar_ctrl_pkg::REG_STATUS ||
             addr == sar_ctrl_pkg::REG_RESULT;
   endfunction : mapped

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   // assert at once, release after two clean edges
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_q = rst_sync_q[1];

   // ------------------------------------------------------------
   // core domain
   // ------------------------------------------------------------
   // pin events seen only through their second sync stage
   assign dev_reset = c_q.rpin_s[1];
   assign cnv_rise = c_q.cnv_s[1] & ~c_q.cnv_s[2];
   assign frame_end = c_q.ben_s[1] & ~c_q.ben_s[2];
   assign word_new = c_q.rdy_s[1] & ~c_q.rdy_s[2];
   assign keep = c_q.comp_s[1];
   assign next_code = keep ? c_q.dac : c_q.code;

   // sequencer write: a word after an empty frame restarts the list
   always_comb begin
      seq_port.wr_en = word_new & l_q.cfg_sh[sar_ctrl_pkg::CFG_VALID_BIT] & ~dev_reset &
                       (c_q.seq_new || c_q.depth != (AW+1)'(SEQ_DEPTH));
      seq_port.wr_addr = c_q.seq_new ? '0 : c_q.depth[AW-1:0];
      seq_port.wr_data = l_q.cfg_sh;
      seq_port.rd_addr = c_q.seq_rd;
   end

   // next state of the core record
   always_comb begin
      c_d = c_q;
      c_d.ben_s = {c_q.ben_s[1:0], bus_enable_low};
      c_d.cnv_s = {c_q.cnv_s[1:0], convert_strobe};
      c_d.rpin_s = {c_q.rpin_s[0], reset_in};
      c_d.comp_s = {c_q.comp_s[0], comp_in};
      c_d.rdy_s = {c_q.rdy_s[1:0], l_q.rdy};

      // write side of the register bus
      if (s_axi_awvalid && !c_q.aw_have) begin
         c_d.aw_have = 1'b1;
         c_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !c_q.w_have) begin
         c_d.w_have = 1'b1;
         c_d.w_data = s_axi_wdata;
         c_d.w_strb0 = s_axi_wstrb[0];
      end
      if (c_q.bvalid && s_axi_bready) begin
         c_d.bvalid = 1'b0;
      end
      if (c_q.aw_have && c_q.w_have && !c_q.bvalid) begin
         c_d.aw_have = 1'b0;
         c_d.w_have = 1'b0;
         c_d.bvalid = 1'b1;
         c_d.bresp = sar_ctrl_pkg::RESP_OKAY;
         if (c_q.aw_addr == sar_ctrl_pkg::REG_CTRL) begin
            if (c_q.w_strb0) begin
               c_d.sleep_req = c_q.w_data[sar_ctrl_pkg::CTRL_SLEEP_BIT];
               c_d.fd_twos = c_q.w_data[sar_ctrl_pkg::CTRL_TWOS_BIT];
            end
         end else if (!mapped(c_q.aw_addr)) begin
            c_d.bresp = sar_ctrl_pkg::RESP_SLVERR;
         end
      end

      // read side of the register bus
      if (c_q.rvalid && s_axi_rready) begin
         c_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !c_q.rvalid) begin
         c_d.rvalid = 1'b1;
         c_d.rdata = read_word(s_axi_araddr, c_q, dev_reset);
         c_d.rresp = mapped(s_axi_araddr) ? sar_ctrl_pkg::RESP_OKAY : sar_ctrl_pkg::RESP_SLVERR;
      end

      // sequencer bookkeeping
      if (seq_port.wr_en) begin
         if (c_q.seq_new) begin
            c_d.depth = (AW+1)'(1);
            c_d.seq_rd = '0;
            c_d.seq_new = 1'b0;
         end else begin
            c_d.depth = c_q.depth + (AW+1)'(1);
         end
      end
      if (word_new && l_q.cfg_sh[sar_ctrl_pkg::CFG_VALID_BIT]) begin
         c_d.word_seen = 1'b1;
      end
      if (frame_end) begin
         c_d.seq_new = c_q.seq_new | ~c_q.word_seen;
         c_d.word_seen = 1'b0;
      end

      // conversion sequencing
      case (c_q.st)
         sar_ctrl_pkg::ST_NAP: begin
            if (c_q.sleep_req) begin
               c_d.st = sar_ctrl_pkg::ST_SLEEP;
            end else if (cnv_rise) begin
               c_d.st = sar_ctrl_pkg::ST_CONV;
               c_d.cfg = (c_q.depth == '0) ? sar_ctrl_pkg::CFG_RESET : seq_port.rd_data;
               c_d.code = '0;
               c_d.bit_idx = IW'(RW-1);
               c_d.dac = weight(IW'(RW-1));
               c_d.wait_cnt = 8'(SETTLE);
            end
         end
         sar_ctrl_pkg::ST_SLEEP: begin
            // strobes are ignored until software wakes the part
            if (!c_q.sleep_req) begin
               c_d.st = sar_ctrl_pkg::ST_NAP;
            end
         end
         sar_ctrl_pkg::ST_CONV: begin
            if (c_q.wait_cnt != 8'h00) begin
               c_d.wait_cnt = c_q.wait_cnt - 8'h01;
            end else if (c_q.bit_idx == '0) begin
               // done: publish result, drop back to nap on our own
               c_d.st = sar_ctrl_pkg::ST_NAP;
               c_d.code = next_code;
               c_d.dac = '0;
               c_d.hold = {format_code(next_code, c_q.cfg, c_q.fd_twos), c_q.cfg};
               if (c_q.depth != '0) begin
                  c_d.seq_rd = ({1'b0, c_q.seq_rd} + (AW+1)'(1) == c_q.depth) ? '0 : c_q.seq_rd + AW'(1);
               end
            end else begin
               c_d.code = next_code;
               c_d.bit_idx = c_q.bit_idx - IW'(1);
               c_d.dac = next_code | weight(c_q.bit_idx - IW'(1));
               c_d.wait_cnt = 8'(SETTLE);
            end
         end
         default: begin
            c_d.st = sar_ctrl_pkg::ST_NAP;
         end
      endcase

      // reset pin halts any conversion and empties the sequencer
      if (dev_reset) begin
         c_d.st = sar_ctrl_pkg::ST_NAP;
         c_d.code = '0;
         c_d.dac = '0;
         c_d.cfg = sar_ctrl_pkg::CFG_RESET;
         c_d.hold = '0;
         c_d.depth = '0;
         c_d.seq_rd = '0;
         c_d.seq_new = 1'b1;
         c_d.word_seen = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         c_q <= '0;
         c_q.ben_s <= 3'h7;
         c_q.st <= sar_ctrl_pkg::ST_NAP;
         c_q.cfg <= sar_ctrl_pkg::CFG_RESET;
         c_q.seq_new <= 1'b1;
         c_q.sleep_req <= sar_ctrl_pkg::CTRL_RESET[sar_ctrl_pkg::CTRL_SLEEP_BIT];
         c_q.fd_twos <= sar_ctrl_pkg::CTRL_RESET[sar_ctrl_pkg::CTRL_TWOS_BIT];
      end else begin
         c_q <= c_d;
      end
   end

   seq_mem #(.DEPTH(SEQ_DEPTH), .AW(AW), .DW(CW)) u_seq_mem (
      .clk(core_clk),
      .rst_n(rst_n_q),
      .port(seq_port.mem)
   );

   // ------------------------------------------------------------
   // link domain
   // ------------------------------------------------------------
   // bus enable high holds the shifter cleared, so stray edges do nothing
   assign link_clr = bus_enable_low | ~rst_n_q;

   // capture config bits, count positions; counter stops after the frame
   always_comb begin
      l_d = l_q;
      if (l_q.cnt < 5'(CW)) begin
         l_d.cfg_sh = {l_q.cfg_sh[CW-2:0], serial_in};
      end
      if (l_q.cnt == 5'(CW-1)) begin
         l_d.rdy = 1'b1;
      end
      if (l_q.cnt != 5'(FW)) begin
         l_d.cnt = l_q.cnt + 5'h01;
      end
   end

   always_ff @(posedge shift_clk or posedge link_clr) begin
      if (link_clr) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // hold is quiet while busy is low, so the link may read it directly
   always_comb begin
      serial_out = 1'b0;
      if (l_q.cnt < 5'(FW)) begin
         serial_out = c_q.hold[5'(FW-1) - l_q.cnt];
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign serial_out_en = ~c_q.ben_s[1] & ~dev_reset & rst_n_q;
   assign busy = (c_q.st == sar_ctrl_pkg::ST_CONV);
   assign nap = (c_q.st == sar_ctrl_pkg::ST_NAP);
   assign sleep_state = (c_q.st == sar_ctrl_pkg::ST_SLEEP);
   assign dac_code = c_q.dac;
   assign mux_config = c_q.cfg[sar_ctrl_pkg::CFG_MUX_LSB +: 4];
   assign input_range = c_q.cfg[sar_ctrl_pkg::CFG_RNG_LSB +: 2];
   assign gain_compression = c_q.cfg[sar_ctrl_pkg::CFG_GC_BIT];
   assign s_axi_awready = ~c_q.aw_have;
   assign s_axi_wready = ~c_q.w_have;
   assign s_axi_bvalid = c_q.bvalid;
   assign s_axi_bresp = c_q.bresp;
   assign s_axi_arready = ~c_q.rvalid;
   assign s_axi_rvalid = c_q.rvalid;
   assign s_axi_rdata = c_q.rdata;
   assign s_axi_rresp = c_q.rresp;

endmodule : sar_conv_ctrl

// *** testbench/sar_ctrl_sva.sv ***
// assertion checker for the converter control block
`timescale 1ns/100ps
module sar_ctrl_sva #(
   parameter int SETTLE = 3
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_arready,
   input wire logic reset_in,
   input wire logic bus_enable_low,
   input wire logic busy,
   input wire logic nap,
   input wire logic sleep_state,
   input wire logic [15:0] dac_code,
   input wire logic serial_out_en
);
   localparam int STEP = SETTLE + 1;
   localparam int STEP2 = STEP + 1;
   localparam int CONV = 16 * STEP;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [3:0] pin_q;
   // busy length counter; pin history excuses a halted conversion
   always_comb cnt_d = busy ? cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h00;
         pin_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
         pin_q <= {pin_q[2:0], reset_in};
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // ------
   // conversion steps
   // ------
   sequence conv_start;
      $rose(busy);
   endsequence
   sequence trial_walk;
      dac_code == 16'h8000 ##[STEP:STEP2] dac_code[14:0] == 15'h4000;
   endsequence
   a_start_from_nap: assert property (conv_start |-> $past(nap))
      else $error("conversion began outside nap");
   a_first_trial: assert property (conv_start |-> trial_walk)
      else $error("trial codes out of order");
   a_busy_length: assert property ($fell(busy) && pin_q == 4'h0 |-> cnt_q == CONV)
      else $error("busy length wrong");
   a_idle_dac_zero: assert property (!busy |-> dac_code == 16'h0000)
      else $error("trial code left while idle");
   a_busy_no_nap: assert property (busy |-> !nap && !sleep_state)
      else $error("nap or sleep during conversion");
   a_sleep_no_start: assert property (sleep_state |=> !$rose(busy))
      else $error("conversion started in sleep");
   // ------
   // link, pins and register bus
   // ------
   a_bus_off_hiz: assert property (bus_enable_low [*4] |-> !serial_out_en)
      else $error("output driven with bus disabled");
   a_reset_halt: assert property (reset_in [*4] |-> !busy && !serial_out_en && dac_code == 16'h0000)
      else $error("reset pin did not halt");
   a_read_ready: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read ready wrong");
endmodule : sar_ctrl_sva

bind sar_conv_ctrl sar_ctrl_sva #(.SETTLE(SETTLE)) u_sva (
   .core_clk(core_clk), .rstn(rstn), .s_axi_rvalid(s_axi_rvalid), .s_axi_arready(s_axi_arready),
   .reset_in(reset_in), .bus_enable_low(bus_enable_low), .busy(busy), .nap(nap),
   .sleep_state(sleep_state), .dac_code(dac_code), .serial_out_en(serial_out_en)
);

// *** testbench/sar_host_model.sv ***
// host side model: convert strobe, serial frames, ideal comparator
`timescale 1ns/100ps
module sar_host_model (
   input wire logic core_clk,
   input wire logic [15:0] dac_code,
   input wire logic serial_out,
   input wire logic serial_out_en,
   output logic convert_strobe,
   output logic comp_in,
   output logic shift_clk,
   output logic bus_enable_low,
   output logic serial_in
);
   logic [15:0] level = 16'h0000;
   // comparator: high while the held sample is at or above the trial code
   assign comp_in = level >= dac_code;
   initial begin
      convert_strobe = 1'h0;
      shift_clk = 1'h0;
      bus_enable_low = 1'h1;
      serial_in = 1'h0;
   end
   // one pulse; only its rising edge matters
   task automatic strobe;
      @(posedge core_clk);
      convert_strobe <= 1'h1;
      repeat (4) @(posedge core_clk);
      convert_strobe <= 1'h0;
   endtask : strobe
   // 24-bit frame; stray clocks come first with the bus disabled
   task automatic frame(input logic [7:0] cfg, input int stray, output logic [23:0] got, output logic en);
      #1.3;
      repeat (stray) begin
         #40 shift_clk <= 1'h1;
         #40 shift_clk <= 1'h0;
      end
      bus_enable_low <= 1'h0;
      #20 en = serial_out_en;
      for (int i = 0; i < 24; i++) begin
         serial_in <= (i < 8) ? cfg[7 - i] : ~serial_in;
         #20 got[23 - i] = serial_out;
         #20 shift_clk <= 1'h1;
         #40 shift_clk <= 1'h0;
      end
      #20 bus_enable_low <= 1'h1;
      serial_in <= ~serial_in; // released line keeps no stale level
      @(posedge core_clk);
   endtask : frame
endmodule : sar_host_model

// *** testbench/test_sar_adc_conversion_serial_control.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
module test_sar_adc_conversion_serial_control;
   logic core_clk = 1'h0;
   logic rstn = 1'h0;
   logic reset_in = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, input_range;
   logic convert_strobe, comp_in, shift_clk, bus_enable_low, serial_in, serial_out, serial_out_en;
   logic busy, nap, sleep_state, gain_compression;
   logic [15:0] dac_code;
   logic [3:0] mux_config;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   sar_conv_ctrl #(.SETTLE(2)) dut (
      .core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .convert_strobe, .reset_in, .comp_in, .busy, .nap, .sleep_state, .dac_code, .mux_config,
      .input_range, .gain_compression, .shift_clk, .bus_enable_low, .serial_in, .serial_out, .serial_out_en
   );
   sar_host_model host (
      .core_clk, .dac_code, .serial_out, .serial_out_en, .convert_strobe, .comp_in, .shift_clk,
      .bus_enable_low, .serial_in
   );
   // ------
   // clock, watchdog, reporting
   // ------
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   // ------
   // register bus master; both ready lines stay high throughout
   // ------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'h1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            break;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
   endtask : axi_rd
   // bounded wait for the busy level
   task automatic wait_busy(input logic v);
      for (int n = 0; n < 200 && busy !== v; n++) @(posedge core_clk);
      check("busy", {31'h0, v}, {31'h0, busy});
   endtask : wait_busy
   // ------
   // main sequence
   // ------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [23:0] f;
      logic e;
      logic [15:0] x;
      logic [7:0] c;
      static logic [7:0] cfgs [3] = '{8'hAB, 8'h9C, 8'hB8};
      static logic [15:0] lv [6] = '{16'h1234, 16'hC001, 16'h8000, 16'h0000, 16'hFFFF, 16'h7FFE};
      repeat (20) @(posedge core_clk);
      rstn <= 1'h1;
      repeat (3) @(posedge core_clk);
      axi_rd(sar_ctrl_pkg::REG_CTRL, d, r);
      check("ctrl reset", 32'h0, d);
      axi_rd(sar_ctrl_pkg::REG_STATUS, d, r);
      check("status reset", 32'h2, d);
      axi_rd(8'h0C, d, r);
      check("unmapped read", {30'h0, sar_ctrl_pkg::RESP_SLVERR}, {d[29:0], r});
      axi_wr(8'h0C, 32'hFFFFFFFF, r);
      check("unmapped write", 32'(sar_ctrl_pkg::RESP_SLVERR), 32'(r));
      axi_wr(sar_ctrl_pkg::REG_STATUS, 32'h0000FFFF, r);
      axi_rd(sar_ctrl_pkg::REG_STATUS, d, r);
      check("status read only", 32'h2, d);
      // three words: unipolar, bipolar, full differential
      for (int k = 0; k < 3; k++) host.frame(cfgs[k], (k == 0) ? 3 : 0, f, e);
      axi_rd(sar_ctrl_pkg::REG_STATUS, d, r);
      check("depth", 32'h3, {27'h0, d[8:4]});
      for (int k = 0; k < 6; k++) begin
         c = cfgs[k % 3];
         if (k == 5) axi_wr(sar_ctrl_pkg::REG_CTRL, 32'h2, r);
         host.level = lv[k];
         host.strobe();
         wait_busy(1'h1);
         if (k == 1) begin
            host.strobe();
            axi_rd(sar_ctrl_pkg::REG_STATUS, d, r);
            check("status busy", 32'h1, {31'h0, d[0]});
         end
         check("word fields", {24'h0, c[6:0]}, {25'h0, mux_config, input_range, gain_compression});
         wait_busy(1'h0);
         x = lv[k];
         if (c[2:1] == sar_ctrl_pkg::RNG_BIPOLAR || (c[2:1] == sar_ctrl_pkg::RNG_FULL_DIFF && k == 5)) x[15] = ~x[15];
         host.frame(8'h00, 0, f, e);
         check("frame", {8'h0, x, c}, {8'h0, f});
         check("drive enable", 32'h1, {31'h0, e});
         axi_rd(sar_ctrl_pkg::REG_RESULT, d, r);
         check("result reg", {8'h0, x, c}, d);
      end
      axi_wr(sar_ctrl_pkg::REG_CTRL, 32'h1, r);
      repeat (4) @(posedge core_clk);
      check("sleep", 32'h1, {31'h0, sleep_state});
      host.strobe();
      repeat (6) @(posedge core_clk);
      check("busy in sleep", 32'h0, {31'h0, busy});
      axi_wr(sar_ctrl_pkg::REG_CTRL, 32'h0, r);
      repeat (4) @(posedge core_clk);
      check("nap", 32'h1, {31'h0, nap});
      // halt a running conversion from the pin
      host.strobe();
      wait_busy(1'h1);
      repeat (6) @(posedge core_clk);
      reset_in <= 1'h1;
      repeat (5) @(posedge core_clk);
      check("halted", 32'h0, {15'h0, busy, dac_code});
      axi_rd(sar_ctrl_pkg::REG_STATUS, d, r);
      check("pin status", 32'hA, {23'h0, d[8:0]});
      reset_in <= 1'h0;
      repeat (5) @(posedge core_clk);
      conclude();
   end
endmodule : test_sar_adc_conversion_serial_control
